// [dmrb_pkg.sv]
// Constants and carrier types shared by the diagnostic monitor register bank.
// Assumes an 8-bit register address space reached by the device control logic.
package dmrb_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] DMRB_ADDR_CFG        = 8'h54;
  localparam logic [7:0] DMRB_ADDR_BAT_HIGH   = 8'h56;
  localparam logic [7:0] DMRB_ADDR_BAT_LOW    = 8'h57;
  localparam logic [7:0] DMRB_ADDR_BIAS_HIGH  = 8'h58;
  localparam logic [7:0] DMRB_ADDR_BIAS_LOW   = 8'h59;
  localparam logic [7:0] DMRB_ADDR_IN1P_HIGH  = 8'h5A;
  localparam logic [7:0] DMRB_ADDR_IN1P_LOW   = 8'h5B;
  localparam logic [7:0] DMRB_ADDR_IN1N_HIGH  = 8'h5C;
  localparam logic [7:0] DMRB_ADDR_IN1N_LOW   = 8'h5D;

  // ==========================================================================
  // Configuration field positions and reset values
  localparam int         DMRB_SUP_FILT_LSB    = 5;
  localparam int         DMRB_BAT_FILT_LSB    = 2;
  localparam int         DMRB_MERGE_BIT       = 0;
  localparam logic [7:0] DMRB_CFG_WMASK       = 8'h6D;
  localparam logic [7:0] DMRB_CFG_RESET       = 8'h48;
  localparam logic [1:0] DMRB_FILT_RESET      = 2'h2;

  // ==========================================================================
  // Channel identifiers
  localparam logic [3:0] DMRB_ID_BAT          = 4'h0;
  localparam logic [3:0] DMRB_ID_BIAS         = 4'h1;
  localparam logic [3:0] DMRB_ID_IN1P         = 4'h2;
  localparam logic [3:0] DMRB_ID_IN1N         = 4'h3;
  localparam int         DMRB_NCH             = 4;
  localparam logic [11:0] DMRB_RES_RESET      = 12'h000;
  localparam logic [7:0] DMRB_READ_ZERO       = 8'h00;

  typedef enum logic [1:0] {
    DMRB_FILT_3M5,
    DMRB_FILT_200K,
    DMRB_FILT_100K,
    DMRB_FILT_NONE
  } dmrb_filt_e;

  // One conversion result from the diagnostic converter.
  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [11:0] value;
  } dmrb_result_s;

  // Register access request from the control logic.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmrb_req_s;

endpackage

// [dmrb_result_slot.sv]
// One diagnostic result slot: holds a 12-bit reading, loaded atomically.
// Assumes load pulses come from logic on the same clock.
module dmrb_result_slot
  import dmrb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Load side
  input  wire logic        load,
  input  wire logic [11:0] value,
  // Readout
  output logic      [11:0] result_ff
);

  // ==========================================================================
  // Storage
  // Both halves sit in one register so one load updates the pair together.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      result_ff <= DMRB_RES_RESET;
    else if (load)
      result_ff <= value; // R13
  end

  // The sampled reset term keeps the release edge out, since the slot is
  // still held in reset there and ignores a load.
  property p_loads;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && load |=> result_ff == $past(value);
  endproperty
  a_loads : assert property (p_loads) // R13
    else $error("Result slot missed a load");

endmodule

// [dmrb_top.sv]
// Diagnostic monitor register bank: filter and fault-merge configuration plus
// read-only converter results. Assumes a same-clock register access port and
// a converter that delivers tagged results on the same clock.
import dmrb_pkg::*;

// Operation
// (R1) Bits 6-5 of config select the supply filter (3.5M,200k,100k,none), reset 2.
// (R2) Bits 3-2 of config select the battery filter in the same coding, reset 2.
// (R3) Config bit 0 merges input overvoltage into battery short when set, reset clear.
// (R4) Config bits 7, 4 and 1 read zero and host writes put only zero there.
// (R5) Each result is 12 bits with the upper eight read at the even address.
// (R6) The odd address returns the low nibble in 7-4 and the channel id in 3-0.
// (R7) Battery result at 0x56/0x57 with id 0, both reset to zero.
// (R8) Bias result at 0x58/0x59 with id 1, low byte resets to 0x01.
// (R9) Input 1 positive result at 0x5A/0x5B with id 2, low byte resets to 0x02.
// (R10) Input 1 negative upper byte at 0x5C, read-only, resets to zero.
// (R11) Input 1 negative low byte at 0x5D with id 3, resets to 0x03.
// (R12) Battery, bias, load and temperature channels auto-enable with any input diag unless forced.
// (R13) Upper byte and low nibble of a result update together.
module dmrb_top
  import dmrb_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // Register access
  input  wire dmrb_req_s    req,
  output logic      [7:0]   rdata_ff,
  output logic              rvalid_ff,
  // Converter results
  input  wire dmrb_result_s result_in,
  // Fault inputs and reporting
  input  wire logic         input_ov_fault,
  input  wire logic         input_bat_short,
  output logic              ov_fault_out_ff,
  output logic              bat_short_out_ff,
  // Channel enables
  input  wire logic         any_input_diag_en,
  input  wire logic         force_en,
  input  wire logic [3:0]   manual_en,
  output logic      [3:0]   chan_en_ff,
  // Filter selects
  output dmrb_filt_e        supply_filter_select,
  output dmrb_filt_e        battery_filter_select
);

  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_rdata;
  logic [11:0] result_q [DMRB_NCH];
  logic        battery_short_merge;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] low_byte(input logic [11:0] r, input logic [3:0] id);
    low_byte = {r[3:0], id}; // R6
  endfunction

  // ==========================================================================
  // Configuration register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cfg_ff <= DMRB_CFG_RESET; // R1 R2 R3
    else if (req.wr && req.addr == DMRB_ADDR_CFG)
      cfg_ff <= req.wdata & DMRB_CFG_WMASK; // R4
  end

  assign supply_filter_select  = dmrb_filt_e'(cfg_ff[DMRB_SUP_FILT_LSB +: 2]); // R1
  assign battery_filter_select = dmrb_filt_e'(cfg_ff[DMRB_BAT_FILT_LSB +: 2]); // R2
  assign battery_short_merge   = cfg_ff[DMRB_MERGE_BIT];

  // ==========================================================================
  // Fault reporting
  // When merged, the separate overvoltage report is held low so software
  // sees exactly one fault source.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ov_fault_out_ff  <= 1'b0;
      bat_short_out_ff <= 1'b0;
    end
    else if (battery_short_merge)
    begin
      ov_fault_out_ff  <= 1'b0; // R3
      bat_short_out_ff <= input_ov_fault | input_bat_short; // R3
    end
    else
    begin
      ov_fault_out_ff  <= input_ov_fault; // R3
      bat_short_out_ff <= input_bat_short;
    end
  end

  // ==========================================================================
  // Channel enables: order is load, bias, battery, temperature.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      chan_en_ff <= 4'h0;
    else if (force_en)
      chan_en_ff <= manual_en; // R12
    else
      chan_en_ff <= {4{any_input_diag_en}}; // R12
  end

  // ==========================================================================
  // Result slots
  genvar g;
  generate
    for (g = 0; g < DMRB_NCH; g++)
    begin : g_slot
      dmrb_result_slot u_slot (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .load      (result_in.valid && result_in.chan == 2'(g)),
        .value     (result_in.value),
        .result_ff (result_q[g])
      ); // R13
    end
  endgenerate

  // ==========================================================================
  // Read decode
  always_comb
  begin
    nxt_rdata = DMRB_READ_ZERO;
    if (req.addr == DMRB_ADDR_CFG)
      nxt_rdata = cfg_ff & DMRB_CFG_WMASK; // R4
    else if (req.addr == DMRB_ADDR_BAT_HIGH)
      nxt_rdata = result_q[0][11:4]; // R5 R7
    else if (req.addr == DMRB_ADDR_BAT_LOW)
      nxt_rdata = low_byte(result_q[0], DMRB_ID_BAT); // R7
    else if (req.addr == DMRB_ADDR_BIAS_HIGH)
      nxt_rdata = result_q[1][11:4]; // R5
    else if (req.addr == DMRB_ADDR_BIAS_LOW)
      nxt_rdata = low_byte(result_q[1], DMRB_ID_BIAS); // R8
    else if (req.addr == DMRB_ADDR_IN1P_HIGH)
      nxt_rdata = result_q[2][11:4]; // R5
    else if (req.addr == DMRB_ADDR_IN1P_LOW)
      nxt_rdata = low_byte(result_q[2], DMRB_ID_IN1P); // R9
    else if (req.addr == DMRB_ADDR_IN1N_HIGH)
      nxt_rdata = result_q[3][11:4]; // R10
    else if (req.addr == DMRB_ADDR_IN1N_LOW)
      nxt_rdata = low_byte(result_q[3], DMRB_ID_IN1N); // R11
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_ff  <= DMRB_READ_ZERO;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= req.rd;
      if (req.rd)
        rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_cfg_write;
    req.wr && req.addr == DMRB_ADDR_CFG;
  endsequence

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!resetn)
    rvalid_ff && $past(req.addr) == DMRB_ADDR_CFG |-> (rdata_ff & 8'h92) == 8'h00;
  endproperty
  a_reserved_zero : assert property (p_reserved_zero) // R4
    else $error("Reserved config bits read nonzero");

  property p_supply_filt;
    @(posedge clk_sys) disable iff (!resetn)
    s_cfg_write |=> cfg_ff[6:5] == $past(req.wdata[6:5]);
  endproperty
  a_supply_filt : assert property (p_supply_filt) // R1
    else $error("Supply filter select not written");

  property p_battery_filt;
    @(posedge clk_sys) disable iff (!resetn)
    s_cfg_write |=> battery_filter_select == dmrb_filt_e'($past(req.wdata[3:2]));
  endproperty
  a_battery_filt : assert property (p_battery_filt) // R2
    else $error("Battery filter select not written");

  property p_merge;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && battery_short_merge && input_ov_fault |=> bat_short_out_ff && !ov_fault_out_ff;
  endproperty
  a_merge : assert property (p_merge) // R3
    else $error("Merged overvoltage not reported as battery short");

  property p_separate;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && !battery_short_merge |=> ov_fault_out_ff == $past(input_ov_fault)
      && bat_short_out_ff == $past(input_bat_short);
  endproperty
  a_separate : assert property (p_separate) // R3
    else $error("Separate fault reporting wrong");

  property p_merge_short;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && battery_short_merge && input_bat_short |=> bat_short_out_ff;
  endproperty
  a_merge_short : assert property (p_merge_short) // R3
    else $error("Merged battery short not reported");

  property p_cfg_resv;
    @(posedge clk_sys) disable iff (!resetn)
    s_cfg_write |=> (cfg_ff & 8'h92) == 8'h00;
  endproperty
  a_cfg_resv : assert property (p_cfg_resv) // R4
    else $error("Reserved config bits stored nonzero");

  property p_cfg_hold;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && !(req.wr && req.addr == DMRB_ADDR_CFG) |=> $stable(cfg_ff);
  endproperty
  a_cfg_hold : assert property (p_cfg_hold) // R1 R2 R3
    else $error("Config changed without a config write");

  property p_bat_id;
    @(posedge clk_sys) disable iff (!resetn)
    req.rd && req.addr == DMRB_ADDR_BAT_LOW |=> rdata_ff[3:0] == 4'h0;
  endproperty
  a_bat_id : assert property (p_bat_id) // R7
    else $error("Battery channel id wrong");

  property p_bias_id;
    @(posedge clk_sys) disable iff (!resetn)
    req.rd && req.addr == DMRB_ADDR_BIAS_LOW |=> rdata_ff[3:0] == 4'h1;
  endproperty
  a_bias_id : assert property (p_bias_id) // R8
    else $error("Bias channel id wrong");

  property p_in1p_id;
    @(posedge clk_sys) disable iff (!resetn)
    req.rd && req.addr == DMRB_ADDR_IN1P_LOW |=> rdata_ff[3:0] == 4'h2;
  endproperty
  a_in1p_id : assert property (p_in1p_id) // R9
    else $error("Input 1 positive channel id wrong");

  property p_in1n_id;
    @(posedge clk_sys) disable iff (!resetn)
    req.rd && req.addr == DMRB_ADDR_IN1N_LOW |=> rdata_ff[3:0] == 4'h3;
  endproperty
  a_in1n_id : assert property (p_in1n_id) // R11
    else $error("Input 1 negative channel id wrong");

  property p_high_byte;
    @(posedge clk_sys) disable iff (!resetn)
    req.rd && req.addr == DMRB_ADDR_IN1N_HIGH && !result_in.valid
      |=> rdata_ff == result_q[3][11:4];
  endproperty
  a_high_byte : assert property (p_high_byte) // R10
    else $error("Input 1 negative high byte wrong");

  property p_pair;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && result_in.valid && result_in.chan == 2'd0
      |=> result_q[0] == $past(result_in.value);
  endproperty
  a_pair : assert property (p_pair) // R5 R13
    else $error("Battery result not loaded whole");

  property p_bias_pair;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && result_in.valid && result_in.chan == 2'd1
      |=> result_q[1] == $past(result_in.value);
  endproperty
  a_bias_pair : assert property (p_bias_pair) // R13
    else $error("Bias result not loaded whole");

  property p_in1p_pair;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && result_in.valid && result_in.chan == 2'd2
      |=> result_q[2] == $past(result_in.value);
  endproperty
  a_in1p_pair : assert property (p_in1p_pair) // R13
    else $error("Input 1 positive result not loaded whole");

  property p_in1n_pair;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && result_in.valid && result_in.chan == 2'd3
      |=> result_q[3] == $past(result_in.value);
  endproperty
  a_in1n_pair : assert property (p_in1n_pair) // R13
    else $error("Input 1 negative result not loaded whole");

  property p_auto_en;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && !force_en ##1 !force_en |-> chan_en_ff == {4{$past(any_input_diag_en)}};
  endproperty
  a_auto_en : assert property (p_auto_en) // R12
    else $error("Auto channel enable wrong");

  property p_forced;
    @(posedge clk_sys) disable iff (!resetn)
    resetn && force_en |=> chan_en_ff == $past(manual_en);
  endproperty
  a_forced : assert property (p_forced) // R12
    else $error("Forced channel enable wrong");

  property p_rvalid;
    @(posedge clk_sys) disable iff (!resetn)
    req.rd |=> rvalid_ff ##1 (rvalid_ff == $past(req.rd));
  endproperty
  a_rvalid : assert property (p_rvalid) // R6
    else $error("Read valid timing wrong");

endmodule

// [tb_top.sv]
// Self-checking bench for the diagnostic monitor register bank top module.
// Assumes the register port answers a read exactly one cycle after the request edge.
module tb_top
  import dmrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t ns: got 0x%h expected 0x%h", $time, (g), (e)); end end

  // ==========================================================================
  // Signals
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] val;
  } dmrb_tb_row_s;

  logic         clk_sys;
  logic         resetn;
  dmrb_req_s    req;
  logic [7:0]   rdata_ff;
  logic         rvalid_ff;
  dmrb_result_s result_in;
  logic         input_ov_fault;
  logic         input_bat_short;
  logic         ov_fault_out_ff;
  logic         bat_short_out_ff;
  logic         any_input_diag_en;
  logic         force_en;
  logic [3:0]   manual_en;
  logic [3:0]   chan_en_ff;
  dmrb_filt_e   supply_filter_select;
  dmrb_filt_e   battery_filter_select;
  int           fails;
  int           comparisons;
  logic [7:0]   got;
  logic [7:0]   cv;
  logic [7:0]   a;
  logic [11:0]  vals [4] = '{12'h0ABC, 12'h035F, 12'h0FED, 12'h0801};
  // Reset image of every mapped place, plus one unmapped address that must read zero.
  dmrb_tb_row_s rows [10] = '{'{8'h54, 8'h48}, '{8'h56, 8'h00}, '{8'h57, 8'h00},
    '{8'h58, 8'h00}, '{8'h59, 8'h01}, '{8'h5A, 8'h00}, '{8'h5B, 8'h02},
    '{8'h5C, 8'h00}, '{8'h5D, 8'h03}, '{8'h55, 8'h00}};

  dmrb_top dut_u (
    .clk_sys               (clk_sys),
    .resetn                (resetn),
    .req                   (req),
    .rdata_ff              (rdata_ff),
    .rvalid_ff             (rvalid_ff),
    .result_in             (result_in),
    .input_ov_fault        (input_ov_fault),
    .input_bat_short       (input_bat_short),
    .ov_fault_out_ff       (ov_fault_out_ff),
    .bat_short_out_ff      (bat_short_out_ff),
    .any_input_diag_en     (any_input_diag_en),
    .force_en              (force_en),
    .manual_en             (manual_en),
    .chan_en_ff            (chan_en_ff),
    .supply_filter_select  (supply_filter_select),
    .battery_filter_select (battery_filter_select)
  );

  // ==========================================================================
  // Bus tasks
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    `CHK(rvalid_ff, 1'b1)
    d = rdata_ff;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  task automatic chk_rd(input logic [7:0] ad, input logic [7:0] e);
    rd(ad, got);
    `CHK(got, e)
  endtask

  task automatic run_table();
    for (int i = 0; i < 10; i++)
      chk_rd(rows[i].addr, rows[i].val);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // A hung sequence would otherwise never reach the verdict.
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    req = '0;
    result_in = '0;
    input_ov_fault = 1'b0;
    input_bat_short = 1'b0;
    any_input_diag_en = 1'b0;
    force_en = 1'b0;
    manual_en = 4'h0;
    fails = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    run_table();
    `CHK({supply_filter_select, battery_filter_select}, 4'hA)
    for (int c = 0; c < 4; c++)
    begin
      cv = {1'b0, c[1:0], 1'b0, c[1:0], 1'b0, c[0]};
      wr(DMRB_ADDR_CFG, cv);
      chk_rd(DMRB_ADDR_CFG, cv);
      `CHK(supply_filter_select, dmrb_filt_e'(c[1:0]))
      `CHK(battery_filter_select, dmrb_filt_e'(c[1:0]))
      @(posedge clk_sys);
      input_ov_fault <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK({ov_fault_out_ff, bat_short_out_ff}, c[0] ? 2'b01 : 2'b10)
    end
    // Merge is still set: a short alone must show up as the battery short.
    @(posedge clk_sys);
    input_ov_fault <= 1'b0;
    input_bat_short <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK({ov_fault_out_ff, bat_short_out_ff}, 2'b01)
    // A host write of 0x21 selects the 200k supply filter, 3.5M battery filter and merge.
    wr(DMRB_ADDR_CFG, 8'h21);
    chk_rd(DMRB_ADDR_CFG, 8'h21);
    `CHK(supply_filter_select, DMRB_FILT_200K)
    `CHK(battery_filter_select, DMRB_FILT_3M5)
    wr(DMRB_ADDR_IN1N_HIGH, 8'hFF);
    chk_rd(DMRB_ADDR_IN1N_HIGH, 8'h00);
    for (int ch = 0; ch < 4; ch++)
    begin
      @(posedge clk_sys);
      result_in <= '{valid: 1'b1, chan: ch[1:0], value: vals[ch]};
      @(posedge clk_sys);
      result_in <= '0;
      a = 8'h56 + {ch[6:0], 1'b0};
      chk_rd(a, vals[ch][11:4]);
      chk_rd(a + 8'h01, {vals[ch][3:0], ch[3:0]});
    end
    @(posedge clk_sys);
    any_input_diag_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(chan_en_ff, 4'hF)
    @(posedge clk_sys);
    force_en <= 1'b1;
    manual_en <= 4'h9;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(chan_en_ff, 4'h9)
    @(posedge clk_sys);
    force_en <= 1'b0;
    any_input_diag_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(chan_en_ff, 4'h0)
    // A second reset in mid-run must restore every reset image.
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    run_table();
    stop_test();
  end

endmodule
